/* File: shared/lcd_map.svh */
// register offsets, field positions and reset values of the link diag block
`ifndef LCD_MAP_SVH
`define LCD_MAP_SVH
`define LCD_OFS_FINE 32'h4000_0040
`define LCD_OFS_BASE 32'h4000_0044
`define LCD_OFS_WAKE 32'h4000_0048
`define LCD_OFS_DCTL 32'h4000_0050
`define LCD_OFS_DSTAT 32'h4000_0054
`define LCD_OFS_ZMAX 32'h4000_0058
`define LCD_OFS_ZMIN 32'h4000_005c
`define LCD_OFS_ERR 32'h4000_0060
`define LCD_FINE_W 10
`define LCD_BASE_W 27
`define LCD_SEL_W 6
`define LCD_EN_BIT0 7
`define LCD_PORT_STRIDE 8
`define LCD_ZONE_HI 16
`define LCD_WAKE_BIT 0
`define LCD_ERR_LO 9
`define LCD_ERR_HI 17
`define LCD_ERR_IRQ 17
`define LCD_ERR_RXBUF 16
`define LCD_ERR_TXBUF 15
`define LCD_ERR_RXDESC 14
`define LCD_ERR_TXDESC 13
`define LCD_ERR_FMT 12
`define LCD_ERR_CHMAP 11
`define LCD_ERR_ADV 10
`define LCD_ERR_IFS 9
`define LCD_RST_VAL 32'h0000_0000
`endif

/* File: shared/lcd_pkg.sv */
// types shared by the link diag and error register block
package lcd_pkg;
  // kind of radio event being checked
  typedef enum logic [2:0] {
    LCD_EVT_IDLE,
    LCD_EVT_ADV,
    LCD_EVT_SCAN,
    LCD_EVT_INIT,
    LCD_EVT_MASTER,
    LCD_EVT_SLAVE
  } lcd_evt_t;
  // wake correction sequencing
  typedef enum logic {
    LCD_WK_IDLE,
    LCD_WK_PEND
  } lcd_wake_t;
endpackage

/* File: core/lcd_regs.sv */
// link core correction, diagnostic port, debug zone and error status registers
`timescale 1ns/1ps
`include "lcd_map.svh"
//
// Contract
// - hold 10-bit fine counter phase correction
// - hold 27-bit base time correction
// - apply bit loads corrections after wake, self-clears
// - disabled diagnostic port drives all zeros
// - 6-bit selector picks group when enabled
// - status register reads four live debug buses
// - register zone upper limit in bits 31:16
// - register zone lower limit in bits 31:16
// - exchange memory zone limits in bits 15:0
// - bit 17 flags unacknowledged back-to-back event irq
// - bit 16 flags null rx buffer pointer
// - bit 15 flags null tx buffer pointer
// - bit 14 flags null rx descriptor pointer
// - bit 13 flags null tx descriptor pointer
// - bit 12 flags invalid control format
// - bit 11 flags channel map count mismatch
// - bit 10 flags advertising interval underrun
// - bit 9 flags interframe space underrun
module lcd_regs
  import lcd_pkg::*;
#(
  parameter int NUM_GROUPS = 64,
  parameter int DESC_W = 15,
  parameter int PTR_W = 16,
  parameter int MAP_W = 37
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // register port
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // wake correction
  input wire logic wake_done_i,
  input wire logic sleep_enter_i,
  output logic corr_load_o,
  output logic counters_enable_o,
  output logic [`LCD_FINE_W-1:0] fine_phase_correction_o,
  output logic [`LCD_BASE_W-1:0] base_time_correction_value_o,
  // diagnostic groups and buses
  input wire logic [NUM_GROUPS*8-1:0] diag_groups_i,
  output logic [7:0] debug_bus_out_0_o,
  output logic [7:0] debug_bus_out_1_o,
  output logic [7:0] debug_bus_out_2_o,
  output logic [7:0] debug_bus_out_3_o,
  // debug zone watch
  input wire logic reg_access_valid_i,
  input wire logic [15:0] reg_access_addr_i,
  input wire logic xmem_access_valid_i,
  input wire logic [15:0] xmem_access_addr_i,
  output logic register_zone_hit_o,
  output logic xmem_zone_hit_o,
  // event checks
  input wire logic evt_check_i,
  input wire lcd_evt_t evt_mode_i,
  input wire logic [PTR_W-1:0] rx_buf_ptr_i,
  input wire logic [PTR_W-1:0] tx_buf_ptr_i,
  input wire logic [7:0] pkt_len_i,
  input wire logic [DESC_W-1:0] rx_desc_ptr_i,
  input wire logic [PTR_W-1:0] tx_desc_ptr_i,
  input wire logic format_invalid_i,
  input wire logic hop_start_i,
  input wire logic [MAP_W-1:0] channel_map_field_i,
  input wire logic [5:0] good_channel_count_i,
  input wire logic unacked_event_irq_i,
  input wire logic advertising_interval_underrun_i,
  input wire logic interframe_space_underrun_i
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // address match, shared by write and read decode
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] ofs);
    addr_hit = (a == ofs);
  endfunction
  // ones count of the channel map
  function automatic logic [5:0] ones_count(input logic [MAP_W-1:0] m);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < MAP_W; i++) begin
      n = n + {5'h00, m[i]};
    end
    ones_count = n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_n;
  // two-stage release so the deassertion is clean
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  logic wr_fine, wr_base, wr_wake, wr_dctl, wr_zmax, wr_zmin, wr_err;
  // write strobes per register
  always_comb begin
    {wr_fine, wr_base, wr_wake, wr_dctl, wr_zmax, wr_zmin, wr_err} = 7'h00;
    if (reg_we_i && clk_en_i) begin
      if (addr_hit(reg_addr_i, `LCD_OFS_FINE)) begin
        wr_fine = 1'b1;
      end else if (addr_hit(reg_addr_i, `LCD_OFS_BASE)) begin
        wr_base = 1'b1;
      end else if (addr_hit(reg_addr_i, `LCD_OFS_WAKE)) begin
        wr_wake = 1'b1;
      end else if (addr_hit(reg_addr_i, `LCD_OFS_DCTL)) begin
        wr_dctl = 1'b1;
      end else if (addr_hit(reg_addr_i, `LCD_OFS_ZMAX)) begin
        wr_zmax = 1'b1;
      end else if (addr_hit(reg_addr_i, `LCD_OFS_ZMIN)) begin
        wr_zmin = 1'b1;
      end else if (addr_hit(reg_addr_i, `LCD_OFS_ERR)) begin
        wr_err = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // correction values
  logic [`LCD_FINE_W-1:0] fine_q;
  logic [`LCD_BASE_W-1:0] base_q;
  // fine counter phase correction, in microseconds
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      fine_q <= `LCD_FINE_W'(0);
    end else if (wr_fine) begin
      fine_q <= reg_wdata_i[`LCD_FINE_W-1:0];
    end
  end
  // base time counter correction, low bits only
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      base_q <= `LCD_BASE_W'(0);
    end else if (wr_base) begin
      base_q <= reg_wdata_i[`LCD_BASE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake correction apply
  lcd_wake_t wake_q;
  logic load_q, cnt_en_q, apply_now;
  logic [`LCD_FINE_W-1:0] fine_out_q;
  logic [`LCD_BASE_W-1:0] base_out_q;
  // a request waits until the wake has finished; writing zero does nothing
  assign apply_now = (wake_q == LCD_WK_PEND) && wake_done_i && clk_en_i;
  // pending flag: set by a write of one, cleared when the apply fires
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= LCD_WK_IDLE;
    end else if (clk_en_i) begin
      case (wake_q)
        LCD_WK_IDLE: begin
          if (wr_wake && reg_wdata_i[`LCD_WAKE_BIT]) begin
            wake_q <= LCD_WK_PEND;
          end
        end
        LCD_WK_PEND: begin
          if (wake_done_i) begin
            wake_q <= LCD_WK_IDLE;
          end
        end
        default: wake_q <= LCD_WK_IDLE;
      endcase
    end
  end
  // load pulse and values toward the fine and base counters
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      load_q <= 1'b0;
      fine_out_q <= `LCD_FINE_W'(0);
      base_out_q <= `LCD_BASE_W'(0);
    end else if (clk_en_i) begin
      load_q <= apply_now;
      if (apply_now) begin
        fine_out_q <= fine_q;
        base_out_q <= base_q;
      end
    end
  end
  // counters run again after the apply; stopped on sleep entry
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_en_q <= 1'b0;
    end else if (clk_en_i) begin
      if (apply_now) begin
        cnt_en_q <= 1'b1;
      end else if (sleep_enter_i) begin
        cnt_en_q <= 1'b0;
      end
    end
  end
  assign corr_load_o = load_q;
  assign counters_enable_o = cnt_en_q;
  assign fine_phase_correction_o = fine_out_q;
  assign base_time_correction_value_o = base_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // diagnostic ports
  logic [31:0] dctl_q;
  logic [7:0] dbus_q [4];
  // only enable and selector bits are stored
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      dctl_q <= `LCD_RST_VAL;
    end else if (wr_dctl) begin
      dctl_q <= reg_wdata_i & 32'hbfbf_bfbf;
    end
  end
  // one registered mux per port; a disabled port is forced low
  for (genvar p = 0; p < 4; p++) begin : g_diag
    logic en;
    logic [`LCD_SEL_W-1:0] sel;
    assign en = dctl_q[p*`LCD_PORT_STRIDE+`LCD_EN_BIT0];
    assign sel = dctl_q[p*`LCD_PORT_STRIDE +: `LCD_SEL_W];
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
        dbus_q[p] <= 8'h00;
      end else if (clk_en_i) begin
        if (en) begin
          dbus_q[p] <= diag_groups_i[32'(sel)*8 +: 8];
        end else begin
          dbus_q[p] <= 8'h00;
        end
      end
    end
  end
  assign debug_bus_out_0_o = dbus_q[0];
  assign debug_bus_out_1_o = dbus_q[1];
  assign debug_bus_out_2_o = dbus_q[2];
  assign debug_bus_out_3_o = dbus_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // debug address zones
  logic [31:0] zmax_q, zmin_q;
  logic reg_hit_q, xmem_hit_q;
  // upper limits: register zone high half, exchange memory low half
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      zmax_q <= `LCD_RST_VAL;
    end else if (wr_zmax) begin
      zmax_q <= reg_wdata_i;
    end
  end
  // lower limits, same layout
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      zmin_q <= `LCD_RST_VAL;
    end else if (wr_zmin) begin
      zmin_q <= reg_wdata_i;
    end
  end
  // inclusive window compare; no access means no hit
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_hit_q <= 1'b0;
      xmem_hit_q <= 1'b0;
    end else if (clk_en_i) begin
      reg_hit_q <= reg_access_valid_i
        && (reg_access_addr_i >= zmin_q[31:`LCD_ZONE_HI])
        && (reg_access_addr_i <= zmax_q[31:`LCD_ZONE_HI]);
      xmem_hit_q <= xmem_access_valid_i
        && (xmem_access_addr_i >= zmin_q[`LCD_ZONE_HI-1:0])
        && (xmem_access_addr_i <= zmax_q[`LCD_ZONE_HI-1:0]);
    end
  end
  assign register_zone_hit_o = reg_hit_q;
  assign xmem_zone_hit_o = xmem_hit_q;

  ////////////////////////////////////////////////////////////////////////////
  // error status
  logic [`LCD_ERR_HI:`LCD_ERR_LO] err_q, err_set, err_clr;
  logic adv_like, conn_like;
  // event classes that the pointer checks depend on
  assign adv_like = (evt_mode_i == LCD_EVT_ADV) || (evt_mode_i == LCD_EVT_SCAN)
    || (evt_mode_i == LCD_EVT_INIT);
  assign conn_like = (evt_mode_i == LCD_EVT_MASTER) || (evt_mode_i == LCD_EVT_SLAVE);
  // set conditions for each sticky error bit
  always_comb begin
    err_set[`LCD_ERR_IRQ] = unacked_event_irq_i;
    err_set[`LCD_ERR_RXBUF] = evt_check_i && (rx_buf_ptr_i == '0);
    err_set[`LCD_ERR_TXBUF] = evt_check_i && (tx_buf_ptr_i == '0)
      && (adv_like || (conn_like && (pkt_len_i != 8'h00)));
    err_set[`LCD_ERR_RXDESC] = evt_check_i && (rx_desc_ptr_i == '0);
    err_set[`LCD_ERR_TXDESC] = evt_check_i && (tx_desc_ptr_i == '0) && adv_like;
    err_set[`LCD_ERR_FMT] = format_invalid_i;
    err_set[`LCD_ERR_CHMAP] = hop_start_i
      && (ones_count(channel_map_field_i) != good_channel_count_i);
    err_set[`LCD_ERR_ADV] = advertising_interval_underrun_i;
    err_set[`LCD_ERR_IFS] = interframe_space_underrun_i;
  end
  // write-one clears; a new event in the same cycle wins over the clear
  assign err_clr = wr_err ? reg_wdata_i[`LCD_ERR_HI:`LCD_ERR_LO] : '0;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= '0;
    end else if (clk_en_i) begin
      err_q <= (err_q & ~err_clr) | err_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  logic [31:0] rdata_q;
  // read data stand for one cycle only; unmapped reads return zero
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `LCD_RST_VAL;
    end else if (clk_en_i) begin
      rdata_q <= 32'h0000_0000;
      if (reg_re_i) begin
        if (addr_hit(reg_addr_i, `LCD_OFS_FINE)) begin
          rdata_q <= {22'h000000, fine_q};
        end else if (addr_hit(reg_addr_i, `LCD_OFS_BASE)) begin
          rdata_q <= {5'h00, base_q};
        end else if (addr_hit(reg_addr_i, `LCD_OFS_WAKE)) begin
          rdata_q <= {31'h0000_0000, wake_q == LCD_WK_PEND};
        end else if (addr_hit(reg_addr_i, `LCD_OFS_DCTL)) begin
          rdata_q <= dctl_q;
        end else if (addr_hit(reg_addr_i, `LCD_OFS_DSTAT)) begin
          rdata_q <= {dbus_q[3], dbus_q[2], dbus_q[1], dbus_q[0]};
        end else if (addr_hit(reg_addr_i, `LCD_OFS_ZMAX)) begin
          rdata_q <= zmax_q;
        end else if (addr_hit(reg_addr_i, `LCD_OFS_ZMIN)) begin
          rdata_q <= zmin_q;
        end else if (addr_hit(reg_addr_i, `LCD_OFS_ERR)) begin
          rdata_q <= {14'h0000, err_q, 9'h000};
        end
      end
    end
  end
  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  fine_write_a: assert property (wr_fine |=> fine_q == $past(reg_wdata_i[9:0]))
    else $error("fine correction not stored");
  base_write_a: assert property (wr_base ##1 !wr_base |=>
    base_q == $past(reg_wdata_i[26:0], 2))
    else $error("base correction not stored");
  wake_apply_a: assert property (apply_now |=> corr_load_o && counters_enable_o
    && wake_q == LCD_WK_IDLE && fine_phase_correction_o == $past(fine_q))
    else $error("wake correction not applied");
  diag_off_a: assert property (clk_en_i && !dctl_q[31] |=> debug_bus_out_3_o == 8'h00)
    else $error("disabled port not zero");
  diag_select_a: assert property (clk_en_i && dctl_q[7] |=>
    debug_bus_out_0_o == $past(diag_groups_i[32'(dctl_q[5:0])*8 +: 8]))
    else $error("port 0 selection wrong");
  diag_status_a: assert property (clk_en_i && reg_re_i
    && reg_addr_i == `LCD_OFS_DSTAT |=>
    reg_rdata_o == $past({dbus_q[3], dbus_q[2], dbus_q[1], dbus_q[0]}))
    else $error("diag status read wrong");
  reg_zone_a: assert property (clk_en_i |=> register_zone_hit_o ==
    $past(reg_access_valid_i && reg_access_addr_i >= zmin_q[31:16]
    && reg_access_addr_i <= zmax_q[31:16]))
    else $error("register zone flag wrong");
  xmem_zone_a: assert property (clk_en_i |=> xmem_zone_hit_o ==
    $past(xmem_access_valid_i && xmem_access_addr_i >= zmin_q[15:0]
    && xmem_access_addr_i <= zmax_q[15:0]))
    else $error("xmem zone flag wrong");
  rxbuf_error_a: assert property (clk_en_i && evt_check_i
    && rx_buf_ptr_i == '0 |=> err_q[16])
    else $error("null rx buffer not flagged");
  irq_sticky_a: assert property (clk_en_i && unacked_event_irq_i ##1 !wr_err [*2]
    |-> err_q[17])
    else $error("event irq error not held");

  wake_cover_c: cover property (wr_wake ##[1:20] corr_load_o);
  diag_cover_c: cover property (dctl_q[31] && debug_bus_out_3_o != 8'h00);
  zone_cover_c: cover property (register_zone_hit_o && xmem_zone_hit_o);
  clear_cover_c: cover property (wr_err && |err_set);

endmodule

/* File: test/lcd_regs_bench.sv */
// self-checking bench for the link diag, debug zone and error register block
`timescale 1ns/1ps
`include "lcd_map.svh"
module lcd_regs_bench import lcd_pkg::*;;
  ////////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic [31:0] reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o;
  logic reg_we_i = 1'b0, reg_re_i = 1'b0, wake_done_i = 1'b0, sleep_enter_i = 1'b0;
  logic corr_load_o, counters_enable_o, register_zone_hit_o, xmem_zone_hit_o;
  logic [9:0] fine_phase_correction_o;
  logic [26:0] base_time_correction_value_o;
  logic [511:0] diag_groups_i = '0;
  logic [7:0] debug_bus_out_0_o, debug_bus_out_1_o, debug_bus_out_2_o, debug_bus_out_3_o;
  logic reg_access_valid_i = 1'b0, xmem_access_valid_i = 1'b0;
  logic [15:0] reg_access_addr_i = '0, xmem_access_addr_i = '0;
  logic evt_check_i = 1'b0, format_invalid_i = 1'b0, hop_start_i = 1'b0;
  logic unacked_event_irq_i = 1'b0, advertising_interval_underrun_i = 1'b0, interframe_space_underrun_i = 1'b0;
  lcd_evt_t evt_mode_i = LCD_EVT_IDLE;
  logic [15:0] rx_buf_ptr_i = 16'h0040, tx_buf_ptr_i = 16'h0040, tx_desc_ptr_i = 16'h0040;
  logic [14:0] rx_desc_ptr_i = 15'h0040;
  logic [7:0] pkt_len_i = 8'h00;
  logic [36:0] channel_map_field_i = '0;
  logic [5:0] good_channel_count_i = '0;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  // register map walk, reset values all zero
  logic [31:0] map_a[8] = '{`LCD_OFS_FINE, `LCD_OFS_BASE, `LCD_OFS_WAKE, `LCD_OFS_DCTL,
                            `LCD_OFS_DSTAT, `LCD_OFS_ZMAX, `LCD_OFS_ZMIN, `LCD_OFS_ERR};
  int ebit[4] = '{17, 12, 10, 9};
  // zone probes straddle both inclusive limits; flags expected independently
  logic [15:0] rza[4] = '{16'h11ff, 16'h1200, 16'h1234, 16'h1235};
  logic [15:0] xza[4] = '{16'h0100, 16'h00ff, 16'h0201, 16'h0200};
  logic rexp[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic xexp[4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  always #2.5 clk_sys_i = ~clk_sys_i;

  lcd_regs lcd_regs_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .wake_done_i(wake_done_i), .sleep_enter_i(sleep_enter_i), .corr_load_o(corr_load_o),
    .counters_enable_o(counters_enable_o), .fine_phase_correction_o(fine_phase_correction_o),
    .base_time_correction_value_o(base_time_correction_value_o),
    .diag_groups_i(diag_groups_i), .debug_bus_out_0_o(debug_bus_out_0_o),
    .debug_bus_out_1_o(debug_bus_out_1_o), .debug_bus_out_2_o(debug_bus_out_2_o),
    .debug_bus_out_3_o(debug_bus_out_3_o),
    .reg_access_valid_i(reg_access_valid_i), .reg_access_addr_i(reg_access_addr_i),
    .xmem_access_valid_i(xmem_access_valid_i), .xmem_access_addr_i(xmem_access_addr_i),
    .register_zone_hit_o(register_zone_hit_o), .xmem_zone_hit_o(xmem_zone_hit_o),
    .evt_check_i(evt_check_i), .evt_mode_i(evt_mode_i), .rx_buf_ptr_i(rx_buf_ptr_i),
    .tx_buf_ptr_i(tx_buf_ptr_i), .pkt_len_i(pkt_len_i), .rx_desc_ptr_i(rx_desc_ptr_i),
    .tx_desc_ptr_i(tx_desc_ptr_i), .format_invalid_i(format_invalid_i),
    .hop_start_i(hop_start_i), .channel_map_field_i(channel_map_field_i),
    .good_channel_count_i(good_channel_count_i), .unacked_event_irq_i(unacked_event_irq_i),
    .advertising_interval_underrun_i(advertising_interval_underrun_i), .interframe_space_underrun_i(interframe_space_underrun_i)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // helpers: compare, verdict, bus cycles
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_we_i <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_re_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  // error bits must stick until cleared by a write of ones
  task automatic err_expect(input logic [31:0] exp);
    chk_rd(`LCD_OFS_ERR, exp);
    chk_rd(`LCD_OFS_ERR, exp);
    wr(`LCD_OFS_ERR, 32'hffff_ffff);
    chk_rd(`LCD_OFS_ERR, 32'h0);
  endtask

  task automatic pulse(input logic [3:0] w, input logic [31:0] exp);
    @(posedge clk_sys_i);
    {unacked_event_irq_i, format_invalid_i, advertising_interval_underrun_i, interframe_space_underrun_i} <= w;
    @(posedge clk_sys_i);
    {unacked_event_irq_i, format_invalid_i, advertising_interval_underrun_i, interframe_space_underrun_i} <= 4'h0;
    err_expect(exp);
  endtask

  task automatic ev(input lcd_evt_t m, input logic [15:0] rxb, input logic [15:0] txb,
                    input logic [7:0] len, input logic [14:0] rxd, input logic [15:0] txd,
                    input logic [31:0] exp);
    @(posedge clk_sys_i);
    evt_mode_i <= m;
    rx_buf_ptr_i <= rxb;
    tx_buf_ptr_i <= txb;
    pkt_len_i <= len;
    rx_desc_ptr_i <= rxd;
    tx_desc_ptr_i <= txd;
    evt_check_i <= 1'b1;
    @(posedge clk_sys_i);
    evt_check_i <= 1'b0;
    err_expect(exp);
  endtask

  task automatic hop(input logic [36:0] map, input logic [5:0] cnt, input logic [31:0] exp);
    @(posedge clk_sys_i);
    channel_map_field_i <= map;
    good_channel_count_i <= cnt;
    hop_start_i <= 1'b1;
    @(posedge clk_sys_i);
    hop_start_i <= 1'b0;
    err_expect(exp);
  endtask

  function automatic logic [7:0] gv(input int g);
    return 8'(g * 3 + 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog so a stuck wait cannot hang the run
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    $display("[ERR] %0t run timed out", $time);
    close_out();
  end

  // main sequence
  initial begin
    for (int g = 0; g < 64; g++) diag_groups_i[g*8 +: 8] = gv(g);
    repeat (20) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    for (int k = 0; k < 8; k++) chk_rd(map_a[k], `LCD_RST_VAL);
    // width masks of the fine and base correction registers
    wr(`LCD_OFS_FINE, 32'hffff_ffff);
    chk_rd(`LCD_OFS_FINE, 32'h0000_03ff);
    wr(`LCD_OFS_BASE, 32'hffff_ffff);
    chk_rd(`LCD_OFS_BASE, 32'h07ff_ffff);
    // strobes with the clock enable low must be ignored
    @(posedge clk_sys_i);
    clk_en_i <= 1'b0;
    wr(`LCD_OFS_FINE, 32'h0000_0155);
    @(posedge clk_sys_i);
    clk_en_i <= 1'b1;
    chk_rd(`LCD_OFS_FINE, 32'h0000_03ff);
    chk_rd(32'h4000_0064, 32'h0);
    // wake correction apply, pending until wake is reported
    wr(`LCD_OFS_WAKE, 32'h0000_0001);
    chk_rd(`LCD_OFS_WAKE, 32'h0000_0001);
    chk({31'h0, corr_load_o}, 32'h0);
    @(posedge clk_sys_i);
    wake_done_i <= 1'b1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (corr_load_o !== 1'b1 && n < 10);
    if (n >= 10) begin
      error_cnt++;
      close_out();
    end
    chk({5'h0, base_time_correction_value_o}, 32'h07ff_ffff);
    chk({21'h0, counters_enable_o, fine_phase_correction_o}, 32'h0000_07ff);
    tick(1);
    chk({31'h0, corr_load_o}, 32'h0);
    chk_rd(`LCD_OFS_WAKE, 32'h0);
    @(posedge clk_sys_i);
    sleep_enter_i <= 1'b1;
    @(posedge clk_sys_i);
    sleep_enter_i <= 1'b0;
    tick(2);
    chk({31'h0, counters_enable_o}, 32'h0);
    // diagnostic ports: reserved bits, selection, per-port disable
    wr(`LCD_OFS_DCTL, 32'hffff_ffff);
    chk_rd(`LCD_OFS_DCTL, 32'hbfbf_bfbf);
    wr(`LCD_OFS_DCTL, 32'hbfaa_9185);
    tick(2);
    chk({debug_bus_out_3_o, debug_bus_out_2_o, debug_bus_out_1_o, debug_bus_out_0_o},
        {gv(63), gv(42), gv(17), gv(5)});
    chk_rd(`LCD_OFS_DSTAT, {gv(63), gv(42), gv(17), gv(5)});
    wr(`LCD_OFS_DCTL, 32'hbf2a_9185);
    wr(`LCD_OFS_DSTAT, 32'h0);
    tick(2);
    chk({24'h0, debug_bus_out_2_o}, 32'h0);
    chk_rd(`LCD_OFS_DSTAT, {gv(63), 8'h00, gv(17), gv(5)});
    // debug zones, inclusive limits on both sides
    wr(`LCD_OFS_ZMAX, 32'h1234_0200);
    wr(`LCD_OFS_ZMIN, 32'h1200_0100);
    chk_rd(`LCD_OFS_ZMAX, 32'h1234_0200);
    chk_rd(`LCD_OFS_ZMIN, 32'h1200_0100);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys_i);
      reg_access_valid_i <= 1'b1;
      xmem_access_valid_i <= 1'b1;
      reg_access_addr_i <= rza[k];
      xmem_access_addr_i <= xza[k];
      tick(2);
      chk({30'h0, register_zone_hit_o, xmem_zone_hit_o}, {30'h0, rexp[k], xexp[k]});
    end
    @(posedge clk_sys_i);
    reg_access_valid_i <= 1'b0;
    xmem_access_valid_i <= 1'b0;
    reg_access_addr_i <= 16'h1210;
    tick(2);
    chk({30'h0, register_zone_hit_o, xmem_zone_hit_o}, 32'h0);
    // error flags raised by single pulses
    for (int k = 0; k < 4; k++) pulse(4'h8 >> k, 32'h1 << ebit[k]);
    // pointer checks across event kinds
    ev(LCD_EVT_IDLE, 16'h0, 16'h40, 8'h00, 15'h40, 16'h40, 32'h0001_0000);
    ev(LCD_EVT_ADV, 16'h40, 16'h0, 8'h00, 15'h40, 16'h40, 32'h0000_8000);
    ev(LCD_EVT_MASTER, 16'h40, 16'h0, 8'h00, 15'h40, 16'h40, 32'h0);
    ev(LCD_EVT_SLAVE, 16'h40, 16'h0, 8'h05, 15'h40, 16'h40, 32'h0000_8000);
    ev(LCD_EVT_IDLE, 16'h40, 16'h40, 8'h00, 15'h0, 16'h40, 32'h0000_4000);
    ev(LCD_EVT_SCAN, 16'h40, 16'h40, 8'h00, 15'h40, 16'h0, 32'h0000_2000);
    ev(LCD_EVT_INIT, 16'h40, 16'h0, 8'h00, 15'h40, 16'h0, 32'h0000_a000);
    ev(LCD_EVT_MASTER, 16'h40, 16'h40, 8'h05, 15'h40, 16'h0, 32'h0);
    // channel map population against good channel count
    hop(37'h5, 6'h02, 32'h0);
    hop(37'h5, 6'h03, 32'h0000_0800);
    hop({37{1'b1}}, 6'h25, 32'h0);
    close_out();
  end
endmodule
